// *** logic/dpat_defs.svh ***
// register offsets, field positions, reset values and timing figures for the pointer block
// What this block does
// - reset clears both pointer page registers and the indirect page register
// - pointer transfers take address bits 23:16 from that pointer's page register
// - register-indirect transfers take 23:16 from indirect page, 15:8 from port two
// - select bit zero picks pointer a, one picks pointer b
// - with auto flip set, steps, loads, code reads and pointer transfers invert the select bit; jumps do not
// - with auto flip clear, pointer instructions leave the select bit alone
// - each pointer steps up or down per its own direction bit
// - the selected pointer feeds transfers, code reads, jumps, steps and loads
// - read or write strobe is active only during an external data transfer
// - strobe width code 7 gives 8 clocks, code 2 gives 3 clocks
// - reset loads strobe width code 7, the slowest strobe
// - a rewritten strobe width applies from the next transfer on
// - every transfer strobe lasts between 3 and 8 clocks
// - on-chip wait register holds 2-bit RAM and 3-bit network and flash fields
// - RAM access takes its wait code plus two clocks
// - network engine and flash accesses take wait code plus three clocks
// - address latch strobe stays high latch length plus one clock, then low
// - reset loads latch length with all ones
// - latch length is used only in multiplexed external bus mode
// - latch strobe lets an outside latch take the address while it is high and keep it after it falls
`ifndef DPAT_DEFS_SVH
`define DPAT_DEFS_SVH
`define DPAT_OFS_PTR_A_LO 8'h82
`define DPAT_OFS_PTR_A_HI 8'h83
`define DPAT_OFS_PTR_B_LO 8'h84
`define DPAT_OFS_PTR_B_HI 8'h85
`define DPAT_OFS_CHOICE 8'h86
`define DPAT_OFS_TIMING 8'h8e
`define DPAT_OFS_PAGE_A 8'h93
`define DPAT_OFS_PAGE_B 8'h95
`define DPAT_OFS_WAIT 8'h9c
`define DPAT_OFS_LATCH 8'h9f
`define DPAT_OFS_IND_PAGE 8'hea
`define DPAT_RST_PTR 16'h0000
`define DPAT_RST_PAGE 8'h00
`define DPAT_RST_CHOICE 8'h00
`define DPAT_RST_TIMING 8'h07
`define DPAT_RST_WAIT 8'hff
`define DPAT_RST_LATCH 8'hff
`define DPAT_BIT_SEL 0
`define DPAT_BIT_FLIP 5
`define DPAT_BIT_DIR_A 6
`define DPAT_BIT_DIR_B 7
`define DPAT_CHOICE_MASK 8'he1
`define DPAT_TIMING_MASK 8'hc7
`define DPAT_STRB_MIN 4'h3
`define DPAT_RAM_BASE 4'h2
`define DPAT_SLOW_BASE 4'h3
`endif

// *** logic/dpat_pkg.sv ***
// types shared by the pointer and access timing block
package dpat_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LATCH,
    ST_STROBE
  } dpat_xfer_st_t;
  typedef enum logic [1:0] {
    TGT_RAM,
    TGT_NET,
    TGT_FLASH,
    TGT_NONE
  } dpat_target_t;
endpackage

// *** logic/dpat_core.sv ***
// data pointers, address extension and data access timing
`timescale 1ns/1ps
`include "dpat_defs.svh"
module dpat_core
  import dpat_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_q,
  input wire logic op_step,
  input wire logic op_load,
  input wire logic [15:0] load_value,
  input wire logic op_code_read,
  input wire logic op_jump,
  input wire logic [7:0] acc_value,
  output logic [15:0] code_addr_q,
  input wire logic xfer_ptr_req,
  input wire logic xfer_ind_req,
  input wire logic xfer_write,
  input wire logic [7:0] ind_reg_value,
  input wire logic [7:0] port_two,
  input wire logic [2:0] ext_bus_mode,
  output logic [23:0] ext_addr_q,
  output logic ext_rd_q,
  output logic ext_wr_q,
  output logic addr_latch_q,
  output logic xfer_busy_q,
  output logic xfer_done_q,
  input wire logic onchip_req,
  input wire logic [1:0] onchip_target,
  output logic onchip_busy_q,
  output logic onchip_done_q
);

  logic [15:0] ptr_a_q;
  logic [15:0] ptr_b_q;
  logic [7:0] page_a_q;
  logic [7:0] page_b_q;
  logic [7:0] ind_page_q;
  logic [7:0] choice_q;
  logic [7:0] timing_q;
  logic [7:0] wait_q;
  logic [7:0] latch_len_q;
  dpat_xfer_st_t st_q;
  logic [8:0] cnt_q;
  logic [3:0] strb_len_q;
  logic dir_write_q;
  logic [3:0] wait_cnt_q;
  logic [15:0] sel_ptr;
  logic sel_bit;
  logic flip_event;
  logic xfer_start;
  logic mux_mode;
  logic wr_choice;

  // strobe width in clocks, unused codes held at the minimum
  function automatic logic [3:0] strobe_clocks(input logic [2:0] code);
    logic [3:0] w;
    w = {1'b0, code} + 4'h1;
    if (w < `DPAT_STRB_MIN) begin
      w = `DPAT_STRB_MIN;
    end
    return w;
  endfunction

  // on-chip access time in clocks per target
  function automatic logic [3:0] wait_clocks(input logic [1:0] tgt, input logic [7:0] cfg);
    logic [3:0] w;
    w = `DPAT_SLOW_BASE;
    unique case (tgt)
      TGT_RAM: w = {2'b00, cfg[7:6]} + `DPAT_RAM_BASE;
      TGT_NET: w = {1'b0, cfg[5:3]} + `DPAT_SLOW_BASE;
      TGT_FLASH: w = {1'b0, cfg[2:0]} + `DPAT_SLOW_BASE;
      default: w = `DPAT_SLOW_BASE;
    endcase
    return w;
  endfunction

  assign sel_bit = choice_q[`DPAT_BIT_SEL];
  assign sel_ptr = sel_bit ? ptr_b_q : ptr_a_q;
  assign xfer_start = (st_q == ST_IDLE) && (xfer_ptr_req || xfer_ind_req);
  // latch phase only for multiplexed modes
  assign mux_mode = ext_bus_mode[0] && !ext_bus_mode[2];
  assign wr_choice = sfr_wr && (sfr_addr == `DPAT_OFS_CHOICE);
  // pointer instructions that flip the select
  assign flip_event = op_step || op_load || op_code_read || (xfer_start && xfer_ptr_req);

  // pointer a: bus writes, then step or load when selected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_a_q <= `DPAT_RST_PTR;
    end else if (sfr_wr && sfr_addr == `DPAT_OFS_PTR_A_LO) begin
      ptr_a_q[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == `DPAT_OFS_PTR_A_HI) begin
      ptr_a_q[15:8] <= sfr_wdata;
    end else if (!sel_bit && op_load) begin
      ptr_a_q <= load_value;
    end else if (!sel_bit && op_step) begin
      ptr_a_q <= choice_q[`DPAT_BIT_DIR_A] ? ptr_a_q - 16'h0001 : ptr_a_q + 16'h0001;
    end
  end

  // pointer b: bus writes, then step or load when selected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_b_q <= `DPAT_RST_PTR;
    end else if (sfr_wr && sfr_addr == `DPAT_OFS_PTR_B_LO) begin
      ptr_b_q[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == `DPAT_OFS_PTR_B_HI) begin
      ptr_b_q[15:8] <= sfr_wdata;
    end else if (sel_bit && op_load) begin
      ptr_b_q <= load_value;
    end else if (sel_bit && op_step) begin
      ptr_b_q <= choice_q[`DPAT_BIT_DIR_B] ? ptr_b_q - 16'h0001 : ptr_b_q + 16'h0001;
    end
  end

  // page extension registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_a_q <= `DPAT_RST_PAGE;
      page_b_q <= `DPAT_RST_PAGE;
      ind_page_q <= `DPAT_RST_PAGE;
    end else if (sfr_wr) begin
      if (sfr_addr == `DPAT_OFS_PAGE_A) begin
        page_a_q <= sfr_wdata;
      end
      if (sfr_addr == `DPAT_OFS_PAGE_B) begin
        page_b_q <= sfr_wdata;
      end
      if (sfr_addr == `DPAT_OFS_IND_PAGE) begin
        ind_page_q <= sfr_wdata;
      end
    end
  end

  // pointer choice register; a bus write wins over a flip in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      choice_q <= `DPAT_RST_CHOICE;
    end else if (wr_choice) begin
      choice_q <= sfr_wdata & `DPAT_CHOICE_MASK;
    end else if (flip_event && choice_q[`DPAT_BIT_FLIP]) begin
      choice_q[`DPAT_BIT_SEL] <= ~choice_q[`DPAT_BIT_SEL];
    end
    // select held when flip is off
  end

  // timing, wait and latch configuration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= `DPAT_RST_TIMING;
      wait_q <= `DPAT_RST_WAIT;
      latch_len_q <= `DPAT_RST_LATCH;
    end else if (sfr_wr) begin
      // new width taken at next start
      if (sfr_addr == `DPAT_OFS_TIMING) begin
        timing_q <= sfr_wdata & `DPAT_TIMING_MASK;
      end
      if (sfr_addr == `DPAT_OFS_WAIT) begin
        wait_q <= sfr_wdata;
      end
      if (sfr_addr == `DPAT_OFS_LATCH) begin
        latch_len_q <= sfr_wdata;
      end
    end
  end

  // register read port, one cycle after the read request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `DPAT_OFS_PTR_A_LO: sfr_rdata_q <= ptr_a_q[7:0];
        `DPAT_OFS_PTR_A_HI: sfr_rdata_q <= ptr_a_q[15:8];
        `DPAT_OFS_PTR_B_LO: sfr_rdata_q <= ptr_b_q[7:0];
        `DPAT_OFS_PTR_B_HI: sfr_rdata_q <= ptr_b_q[15:8];
        `DPAT_OFS_CHOICE: sfr_rdata_q <= choice_q;
        `DPAT_OFS_TIMING: sfr_rdata_q <= timing_q;
        `DPAT_OFS_PAGE_A: sfr_rdata_q <= page_a_q;
        `DPAT_OFS_PAGE_B: sfr_rdata_q <= page_b_q;
        `DPAT_OFS_WAIT: sfr_rdata_q <= wait_q;
        `DPAT_OFS_LATCH: sfr_rdata_q <= latch_len_q;
        `DPAT_OFS_IND_PAGE: sfr_rdata_q <= ind_page_q;
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // code address for table reads and indexed jumps
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      code_addr_q <= 16'h0000;
    end else if (op_code_read || op_jump) begin
      code_addr_q <= sel_ptr + {8'h00, acc_value};
    end
  end

  // external address capture at transfer start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr_q <= 24'h000000;
      dir_write_q <= 1'b0;
      strb_len_q <= `DPAT_STRB_MIN;
    end else if (xfer_start) begin
      dir_write_q <= xfer_write;
      strb_len_q <= strobe_clocks(timing_q[2:0]);
      if (xfer_ptr_req) begin
        ext_addr_q <= {sel_bit ? page_b_q : page_a_q, sel_ptr};
      end else begin
        ext_addr_q <= {ind_page_q, port_two, ind_reg_value};
      end
    end
  end

  // transfer sequencer: optional latch phase, then the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 9'h000;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (xfer_start) begin
            // latch phase is length plus one
            st_q <= mux_mode ? ST_LATCH : ST_STROBE;
            cnt_q <= mux_mode ? {1'b0, latch_len_q} : 9'h000;
          end
        end
        ST_LATCH: begin
          if (cnt_q == 9'h000) begin
            st_q <= ST_STROBE;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        ST_STROBE: begin
          if (cnt_q[3:0] == strb_len_q - 4'h1) begin
            st_q <= ST_IDLE;
            cnt_q <= 9'h000;
          end else begin
            cnt_q <= cnt_q + 9'h001;
          end
        end
        // unused state code falls back to idle
        default: begin
          st_q <= ST_IDLE;
          cnt_q <= 9'h000;
        end
      endcase
    end
  end

  // registered pins of the external transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      addr_latch_q <= 1'b0;
      xfer_busy_q <= 1'b0;
      xfer_done_q <= 1'b0;
    end else begin
      // latch strobe high from transfer start until the latch count reaches zero
      addr_latch_q <= (xfer_start && mux_mode) || (st_q == ST_LATCH && cnt_q != 9'h000);
      // strobe only in the strobe phase
      ext_rd_q <= (st_q == ST_STROBE || (st_q == ST_LATCH && cnt_q == 9'h000)
                   || (xfer_start && !mux_mode)) && !(st_q == ST_STROBE
                   && cnt_q[3:0] == strb_len_q - 4'h1) && !nxt_write();
      ext_wr_q <= (st_q == ST_STROBE || (st_q == ST_LATCH && cnt_q == 9'h000)
                   || (xfer_start && !mux_mode)) && !(st_q == ST_STROBE
                   && cnt_q[3:0] == strb_len_q - 4'h1) && nxt_write();
      xfer_busy_q <= xfer_start || !(st_q == ST_IDLE
                     || (st_q == ST_STROBE && cnt_q[3:0] == strb_len_q - 4'h1));
      xfer_done_q <= st_q == ST_STROBE && cnt_q[3:0] == strb_len_q - 4'h1;
    end
  end

  // direction of the transfer that the pins carry next cycle
  function automatic logic nxt_write();
    return xfer_start ? xfer_write : dir_write_q;
  endfunction

  // on-chip access timer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_q <= 4'h0;
      onchip_busy_q <= 1'b0;
      onchip_done_q <= 1'b0;
    end else if (!onchip_busy_q && onchip_req && onchip_target != TGT_NONE) begin
      // full count loaded so busy stands for exactly the decoded clocks
      wait_cnt_q <= wait_clocks(onchip_target, wait_q);
      onchip_busy_q <= 1'b1;
      onchip_done_q <= 1'b0;
    end else if (onchip_busy_q && wait_cnt_q == 4'h1) begin
      wait_cnt_q <= 4'h0;
      onchip_busy_q <= 1'b0;
      onchip_done_q <= 1'b1;
    end else begin
      wait_cnt_q <= onchip_busy_q ? wait_cnt_q - 4'h1 : 4'h0;
      onchip_done_q <= 1'b0;
    end
  end

endmodule // dpat_core

// *** bench/dpat_core_monitor.sv ***
// assertion checker for the pointer and access timing block
`timescale 1ns/1ps
module dpat_core_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] ext_bus_mode,
  input wire logic [23:0] ext_addr_q,
  input wire logic ext_rd_q,
  input wire logic ext_wr_q,
  input wire logic addr_latch_q,
  input wire logic xfer_busy_q,
  input wire logic xfer_done_q,
  input wire logic onchip_busy_q,
  input wire logic onchip_done_q
);
  logic [3:0] cnt_q;
  // strobe clocks counted so far, held one cycle after the strobe ends, then zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= (ext_rd_q || ext_wr_q) ? cnt_q + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_STRB_BUSY: assert property ((ext_rd_q || ext_wr_q) |-> xfer_busy_q)
    else $error("strobe outside a transfer");
  AST_ONE_STRB: assert property (!(ext_rd_q && ext_wr_q))
    else $error("read and write strobes together");
  AST_STRB_WIDTH: assert property (!(ext_rd_q || ext_wr_q) && cnt_q != 4'h0 |-> cnt_q >= 4'h3 && cnt_q <= 4'h8)
    else $error("strobe width out of range");
  AST_STRB_CAP: assert property (cnt_q <= 4'h8)
    else $error("strobe longer than eight clocks");
  AST_RD_HOLD: assert property ($rose(ext_rd_q) |-> ext_rd_q [*3])
    else $error("read strobe shorter than three clocks");
  AST_DONE_END: assert property ($fell(ext_rd_q || ext_wr_q) |-> xfer_done_q && !xfer_busy_q)
    else $error("no done when strobe ends");
  AST_LATCH_MODE: assert property (addr_latch_q |-> ext_bus_mode[0] && !ext_bus_mode[2])
    else $error("latch strobe outside multiplexed mode");
  AST_LATCH_THEN_STRB: assert property ($fell(addr_latch_q) |-> (ext_rd_q || ext_wr_q) && $stable(ext_addr_q))
    else $error("strobe does not follow latch");
  AST_ADDR_HOLD: assert property (xfer_busy_q && $past(xfer_busy_q) |-> $stable(ext_addr_q))
    else $error("address moved during transfer");
  AST_ONCHIP_MIN: assert property ($rose(onchip_busy_q) |-> onchip_busy_q [*2])
    else $error("on-chip access shorter than two clocks");
  AST_ONCHIP_END: assert property ($fell(onchip_busy_q) |-> onchip_done_q ##1 !onchip_done_q)
    else $error("on-chip done not a single pulse");
  AST_ONCHIP_MAX: assert property (onchip_busy_q [*8] |-> ##[1:3] !onchip_busy_q)
    else $error("on-chip access longer than ten clocks");
  // main scenarios reached
  cover property ($fell(addr_latch_q));
  cover property ($rose(ext_wr_q));
  cover property ($fell(onchip_busy_q));
endmodule // dpat_core_monitor
bind dpat_core dpat_core_monitor u_mon (.*);

// *** bench/dpat_ext_mem.sv ***
// external address latch in front of slow memory
`timescale 1ns/1ps
module dpat_ext_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [23:0] bus_addr,
  input wire logic bus_latch,
  output logic [23:0] held_addr_q
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_addr_q <= 24'h000000;
    end else if (bus_latch) begin
      held_addr_q <= bus_addr;
    end
  end
endmodule // dpat_ext_mem

// *** bench/test_data_pointer_and_access_timing.sv ***
// self-checking bench for the pointer and access timing block
`timescale 1ns/1ps
module test_data_pointer_and_access_timing;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr, sfr_rd, op_step, op_load, op_code_read, op_jump;
  logic xfer_ptr_req, xfer_ind_req, xfer_write, onchip_req;
  logic [7:0] sfr_addr, sfr_wdata, acc_value, ind_reg_value, port_two, sfr_rdata_q;
  logic [15:0] load_value, code_addr_q;
  logic [2:0] ext_bus_mode;
  logic [1:0] onchip_target;
  logic [23:0] ext_addr_q, held_addr_q;
  logic ext_rd_q, ext_wr_q, addr_latch_q, xfer_busy_q, xfer_done_q, onchip_busy_q, onchip_done_q;
  int err_total = 0;
  int samples_checked = 0;
  dpat_core DUT (.*);
  dpat_ext_mem ext_mem (.clock(clock), .rst_n(rst_n), .bus_addr(ext_addr_q),
    .bus_latch(addr_latch_q), .held_addr_q(held_addr_q));
  // 125 MHz clock
  always #4 clock = ~clock;
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 chk(24'(sfr_rdata_q), 24'(e));
  endtask
  task automatic op(input logic [3:0] v);
    @(posedge clock);
    {op_step, op_load, op_code_read, op_jump} <= v;
    @(posedge clock);
    {op_step, op_load, op_code_read, op_jump} <= 4'h0;
  endtask
  // one transfer: counts latch and strobe clocks up to done
  task automatic xfer(input logic ind, input logic w, input logic [23:0] ea, input int el,
    input int ew);
    int k, nl, nw;
    nl = 0;
    nw = 0;
    @(posedge clock);
    xfer_ptr_req <= !ind;
    xfer_ind_req <= ind;
    xfer_write <= w;
    @(posedge clock);
    xfer_ptr_req <= 1'b0;
    xfer_ind_req <= 1'b0;
    // pins rise in the first cycle after the taking edge, so count from there
    #1;
    for (k = 0; k < 300 && xfer_done_q !== 1'b1; k++) begin
      nl += addr_latch_q;
      nw += w ? ext_wr_q : ext_rd_q;
      @(posedge clock);
      #1;
    end
    if (k == 300) begin
      err_total++;
      test_done();
    end
    chk(ext_addr_q, ea);
    chk(24'(nl), 24'(el));
    chk(24'(nw), 24'(ew));
  endtask
  // one on-chip access: counts busy clocks up to done
  task automatic onc(input logic [1:0] t, input int n);
    int k, nb;
    nb = 0;
    @(posedge clock);
    onchip_req <= 1'b1;
    onchip_target <= t;
    @(posedge clock);
    onchip_req <= 1'b0;
    // busy rises in the first cycle after the taking edge
    #1;
    for (k = 0; k < 50 && onchip_done_q !== 1'b1; k++) begin
      nb += onchip_busy_q;
      @(posedge clock);
      #1;
    end
    if (k == 50) begin
      err_total++;
      test_done();
    end
    chk(24'(nb), 24'(n));
  endtask
  task automatic t_reset();
    logic [7:0] a[10] = '{8'h93, 8'h95, 8'hea, 8'h8e, 8'h9f, 8'h9c, 8'h86, 8'h82, 8'h85, 8'h81};
    logic [7:0] e[10] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(a[i], e[i]);
    end
    $display("t_reset done");
  endtask
  task automatic t_ptr();
    wr(8'h93, 8'h12);
    wr(8'h95, 8'h34);
    wr(8'h83, 8'h10);
    wr(8'h85, 8'h20);
    wr(8'h84, 8'h05);
    xfer(1'b0, 1'b0, 24'h121000, 0, 8);
    wr(8'h86, 8'h81);
    xfer(1'b0, 1'b1, 24'h342005, 0, 8);
    op(4'h8);
    rd(8'h84, 8'h04);
    rd(8'h86, 8'h81);
    op(4'h1);
    rd(8'h85, 8'h20);
    chk(24'(code_addr_q), 24'h002014);
    wr(8'h86, 8'h00);
    op(4'h8);
    rd(8'h82, 8'h01);
    wr(8'h86, 8'h40);
    op(4'h8);
    rd(8'h82, 8'h00);
    op(4'h4);
    op(4'h2);
    rd(8'h83, 8'h56);
    chk(24'(code_addr_q), 24'h005688);
    $display("t_ptr done");
  endtask
  task automatic t_flip();
    logic [7:0] e;
    e = 8'h20;
    wr(8'h86, 8'h20);
    for (int i = 0; i < 4; i++) begin
      op(4'h8 >> i);
      e[0] = e[0] ^ (i < 3);
      rd(8'h86, e);
    end
    xfer(1'b0, 1'b0, 24'h345678, 0, 8);
    rd(8'h86, 8'h20);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'he1);
    $display("t_flip done");
  endtask
  task automatic t_width();
    wr(8'h86, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h8e, 8'(c));
      xfer(1'b0, c[0], 24'h125679, 0, c < 3 ? 3 : c + 1);
    end
    wr(8'h8e, 8'hfa);
    rd(8'h8e, 8'hc2);
    $display("t_width done");
  endtask
  task automatic t_mux();
    wr(8'h9f, 8'h02);
    ext_bus_mode <= 3'h1;
    xfer(1'b0, 1'b1, 24'h125679, 3, 3);
    chk(held_addr_q, 24'h125679);
    wr(8'hea, 8'hab);
    ext_bus_mode <= 3'h3;
    xfer(1'b1, 1'b0, 24'habcdef, 3, 3);
    chk(held_addr_q, 24'habcdef);
    wr(8'h9f, 8'h00);
    ext_bus_mode <= 3'h5;
    xfer(1'b0, 1'b0, 24'h125679, 0, 3);
    chk(held_addr_q, 24'habcdef);
    @(posedge clock);
    ext_bus_mode <= 3'h1;
    xfer(1'b0, 1'b0, 24'h125679, 1, 3);
    $display("t_mux done");
  endtask
  task automatic t_onchip();
    wr(8'h9c, 8'h00);
    onc(2'h0, 2);
    onc(2'h1, 3);
    onc(2'h2, 3);
    wr(8'h9c, 8'h99);
    onc(2'h0, 4);
    onc(2'h1, 6);
    onc(2'h2, 4);
    wr(8'h9c, 8'hff);
    onc(2'h0, 5);
    onc(2'h1, 10);
    $display("t_onchip done");
  endtask
  // reset, then the scenarios in order
  initial begin
    {sfr_wr, sfr_rd, op_step, op_load, op_code_read, op_jump} = 6'h00;
    {xfer_ptr_req, xfer_ind_req, xfer_write, onchip_req} = 4'h0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    acc_value = 8'h10;
    ind_reg_value = 8'hef;
    port_two = 8'hcd;
    load_value = 16'h5678;
    ext_bus_mode = 3'h0;
    onchip_target = 2'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ptr();
    t_flip();
    t_width();
    t_mux();
    t_onchip();
    test_done();
  end
endmodule // test_data_pointer_and_access_timing
